// [verif/bcfb_exec_assertions.sv]
// Concurrent checks on the ports of the bit-clear and flag-branch execute unit.
`timescale 1ns/1ps
module bcfb_exec_assertions
  import bcfb_pkg::*;
#(
  parameter int PCW = PC_W // Counter width.
) (
  input wire logic I_CLK, // Clock.
  input wire logic I_RESETN, // Reset.
  input wire logic [15:0] I_INSTR, // Word.
  input wire logic [PCW-1:0] I_INSTR_PC, // Word address.
  input wire flags_t I_FLAGS, // Flags.
  input wire logic [BANK_W-1:0] I_BSR, // Bank.
  input wire logic I_EXT_EN, // Extended set.
  input wire logic [DADDR_W-1:0] I_INDEX_BASE, // Index base.
  input wire logic [7:0] I_DATA_RDATA, // Read data.
  input wire phase_t O_PHASE, // Phase.
  input wire data_req_t O_DATA, // Data request.
  input wire logic O_PC_WR, // Counter write.
  input wire logic [PCW-1:0] O_PC_VALUE, // Counter value.
  input wire logic O_FLUSH, // Flush cycle.
  input wire logic O_CLAIMED, // Claimed word.
  input wire logic O_INDEXED, // Indexed mode.
  input wire logic O_BRANCH_TAKEN, // Taken.
  input wire logic O_STATUS_WR // Flag write.
);
  logic low;
  logic cond;
  logic is_br;
  assign low = I_INSTR[7:0] <= INDEXED_MAX;
  assign cond = (I_INSTR[10] ? I_FLAGS.negative : I_FLAGS.carry) ^ I_INSTR[8];
  assign is_br = O_PHASE == PH_Q4 && O_CLAIMED && I_INSTR[15:12] == 4'he;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  rd_then_wr_a: assert property (O_DATA.rd |-> O_PHASE == PH_Q3 ##1 (O_DATA.wr && !O_DATA.rd))
    else $error("read not followed by write");
  addr_map_a: assert property (O_DATA.rd |-> O_DATA.addr == (
    I_INSTR[8] ? {I_BSR, I_INSTR[7:0]} :
    (I_EXT_EN && low) ? DADDR_W'(I_INDEX_BASE + I_INSTR[7:0]) :
    {low ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, I_INSTR[7:0]}))
    else $error("wrong operand address");
  indexed_mode_a: assert property (O_DATA.rd |-> O_INDEXED == (!I_INSTR[8] && I_EXT_EN && low))
    else $error("wrong indexed mode");
  clear_data_a: assert property (O_DATA.wr |->
    O_DATA.wdata == ($past(I_DATA_RDATA) & ~(8'h01 << I_INSTR[11:9])))
    else $error("wrong cleared data");
  branch_cond_a: assert property (is_br |->
    O_PC_WR == cond && O_BRANCH_TAKEN == cond)
    else $error("wrong branch decision");
  pc_target_a: assert property (O_PC_WR |-> O_PC_VALUE ==
    PCW'(I_INSTR_PC + PC_STEP + {I_INSTR[7:0], 1'b0} - (I_INSTR[7] ? 21'h200 : 21'h0)))
    else $error("wrong branch target");
  pc_wr_pulse_a: assert property (O_PC_WR |-> O_PHASE == PH_Q4 ##1 (!O_PC_WR && O_FLUSH))
    else $error("counter write misplaced");
  flush_len_a: assert property ($rose(O_FLUSH) |-> O_FLUSH[*4] ##1 !O_FLUSH)
    else $error("flush length wrong");
  no_flush_a: assert property (is_br && !O_PC_WR |=> !O_FLUSH)
    else $error("flush after untaken branch");
  no_status_a: assert property (!O_STATUS_WR)
    else $error("status flag written");
  taken_pulse_a: assert property (O_BRANCH_TAKEN |-> O_PHASE == PH_Q4 ##1 !O_BRANCH_TAKEN)
    else $error("taken indication misplaced");
  flush_unclaimed_a: assert property (O_FLUSH && O_PHASE != PH_Q1 |-> !O_CLAIMED)
    else $error("word claimed in idle cycle");
  cover property (O_PC_WR);
  cover property (O_DATA.wr && O_INDEXED);
  cover property (is_br && !O_PC_WR);
endmodule

// [verif/tb.sv]
// Self-checking bench for the bit-clear and flag-branch execute unit.
`timescale 1ns/1ps
module tb;
  import bcfb_pkg::*;
  localparam int PCW = PC_W;
  logic I_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic vld = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [PCW-1:0] ipc = '0;
  flags_t flg = '0;
  logic [BANK_W-1:0] bank_select_reg = '0;
  logic ext = 1'b0;
  logic [DADDR_W-1:0] base = 12'hfd0;
  logic [7:0] rdat = 8'h00;
  phase_t phase;
  data_req_t dreq;
  logic pc_wr, flush, claimed, indexed, taken, st_wr;
  logic [PCW-1:0] pc_val;
  int error_cnt = 0;
  int checks_done = 0;
  always #5 I_CLK = ~I_CLK;
  bcfb_exec #(.PCW(PCW)) u_dut (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_INSTR_VALID(vld), .I_INSTR(instr),
    .I_INSTR_PC(ipc), .I_FLAGS(flg), .I_BSR(bank_select_reg), .I_EXT_EN(ext), .I_INDEX_BASE(base), .I_DATA_RDATA(rdat),
    .O_PHASE(phase), .O_DATA(dreq), .O_PC_WR(pc_wr), .O_PC_VALUE(pc_val), .O_FLUSH(flush),
    .O_CLAIMED(claimed), .O_INDEXED(indexed), .O_BRANCH_TAKEN(taken), .O_STATUS_WR(st_wr));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Waits for Q4, then presents the word through Q1 so that it is sampled at the end of Q1.
  task automatic issue(input logic [15:0] w, input logic [PCW-1:0] pc, input flags_t f, input logic [7:0] rd,
                       input logic [3:0] bs, input logic e, input logic v);
    while (phase !== PH_Q4) @(negedge I_CLK);
    @(posedge I_CLK);
    instr <= w;
    ipc <= pc;
    flg <= f;
    rdat <= rd;
    bank_select_reg <= bs;
    ext <= e;
    vld <= v;
    @(posedge I_CLK);
    vld <= 1'b0;
  endtask
  task automatic t_clr(input logic [2:0] b, input logic a, input logic [7:0] f, input logic [3:0] bs,
                       input logic e, input logic [7:0] rd);
    logic ix;
    logic [DADDR_W-1:0] ea;
    ix = !a && e && f <= INDEXED_MAX;
    ea = a ? {bs, f} : ix ? base + f : {f <= INDEXED_MAX ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    issue({OPC_BIT_CLEAR, b, a, f}, '0, 2'b11, rd, bs, e, 1'b1);
    repeat (2) @(negedge I_CLK);
    chk({dreq.rd, indexed, claimed, dreq.addr}, {1'b1, ix, 1'b1, ea}, "read");
    @(negedge I_CLK);
    chk({dreq.wr, st_wr, dreq.wdata}, {2'b10, rd & ~(8'h01 << b)}, "write");
    $display("test clear %h done", {OPC_BIT_CLEAR, b, a, f});
  endtask
  task automatic t_br(input logic [7:0] op, input logic [7:0] n, input flags_t f, input logic [PCW-1:0] pc);
    logic go;
    logic [PCW-1:0] exp;
    go = (op[2] ? f.negative : f.carry) ^ op[0];
    exp = pc + PC_STEP + {{12{n[7]}}, n, 1'b0};
    issue({op, n}, pc, f, 8'h00, 4'h0, 1'b0, 1'b1);
    repeat (3) @(negedge I_CLK);
    chk({pc_wr, taken, claimed, phase}, {go, go, 1'b1, PH_Q4}, "branch");
    if (go) chk(pc_val, exp, "target");
    repeat (4) begin
      @(negedge I_CLK);
      chk({pc_wr, taken, st_wr, flush}, {3'b000, go}, "flush");
    end
    $display("test branch %h flags %b done", op, f);
  endtask
  task automatic t_refuse();
    issue({OPC_BR_NEG, 8'h04}, 21'h000100, 2'b01, 8'h00, 4'h0, 1'b0, 1'b1);
    @(negedge I_CLK);
    issue({OPC_BIT_CLEAR, 3'd0, 1'b1, 8'h10}, '0, 2'b00, 8'hff, 4'h1, 1'b0, 1'b1);
    repeat (3) begin
      @(negedge I_CLK);
      chk({dreq.rd, dreq.wr, flush, claimed}, 4'b0010, "refused");
    end
    // An unknown opcode, then a known branch whose valid strobe is low: neither may act.
    for (int j = 0; j < 2; j++) begin
      issue(j ? {OPC_BR_CARRY, 8'h04} : 16'he104, 21'h000100, 2'b11, 8'h00, 4'h0, 1'b0, j == 0);
      repeat (3) @(negedge I_CLK);
      chk({claimed, pc_wr, taken, dreq.rd, dreq.wr}, 5'b00000, "ignored");
    end
    $display("test refuse done");
  endtask
  initial begin
    repeat (20) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    repeat (4) @(negedge I_CLK);
    t_clr(3'd7, 1'b0, 8'h60, 4'h5, 1'b1, 8'hc7);
    for (int i = 0; i < 8; i++) t_clr(i[2:0], i[0], {i[2:1], 6'h1f}, i[3:0], i[1], 8'hff);
    for (int k = 0; k < 16; k++) t_br({5'b11100, k[3], 1'b1, k[2]}, k[0] ? 8'h80 : 8'h7f, flags_t'(k[1:0]),
      k[1] ? 21'h1ffff0 : 21'h000010);
    t_refuse();
    conclude();
  end
  initial begin
    #30000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
bind bcfb_exec bcfb_exec_assertions #(.PCW(PCW)) u_chk (.I_CLK, .I_RESETN, .I_INSTR, .I_INSTR_PC, .I_FLAGS, .I_BSR,
  .I_EXT_EN, .I_INDEX_BASE, .I_DATA_RDATA, .O_PHASE, .O_DATA, .O_PC_WR, .O_PC_VALUE, .O_FLUSH, .O_CLAIMED,
  .O_INDEXED, .O_BRANCH_TAKEN, .O_STATUS_WR);

// [verilog/bcfb_exec.sv]
// Decode and execute unit for single-bit clear and the carry and negative flag branches.
// Notes on behaviour
// - Decode 1001 opcode, clear indexed register bit.
// - Bank bit zero selects the access bank.
// - Bank bit one uses bank select register.
// - Extended set, low addresses become indexed offsets.
// - Opcode E6 branches when negative is set.
// - Opcode E3 branches when carry is clear.
// - Opcode E7 branches when negative is clear.
// - Offset is signed and doubled before adding.
// - Target is instruction address plus two plus offset.
// - Taken branch two cycles, counter written Q4.
// - Opcode E2 branches when carry is set.
`timescale 1ns/1ps
module bcfb_exec
  import bcfb_pkg::*;
#(
  parameter int PCW = PC_W // Program counter width.
) (
  input wire logic I_CLK, // Core clock, four per instruction cycle.
  input wire logic I_RESETN, // Asynchronous reset, active low.
  input wire logic I_INSTR_VALID, // Fetched word is valid, sampled in Q1.
  input wire logic [15:0] I_INSTR, // Fetched instruction word.
  input wire logic [PCW-1:0] I_INSTR_PC, // Address of the fetched word.
  input wire flags_t I_FLAGS, // Carry and negative status flags.
  input wire logic [BANK_W-1:0] I_BSR, // Bank select register.
  input wire logic I_EXT_EN, // Extended instruction set enabled.
  input wire logic [DADDR_W-1:0] I_INDEX_BASE, // Base pointer for indexed offset.
  input wire logic [7:0] I_DATA_RDATA, // Register file read data, valid in Q3.
  output phase_t O_PHASE, // Current quarter phase.
  output data_req_t O_DATA, // Register file request.
  output logic O_PC_WR, // Program counter write strobe, Q4.
  output logic [PCW-1:0] O_PC_VALUE, // Program counter write value.
  output logic O_FLUSH, // Second, idle cycle of a taken branch.
  output logic O_CLAIMED, // Current instruction belongs to this unit.
  output logic O_INDEXED, // Operand uses indexed literal offset.
  output logic O_BRANCH_TAKEN, // Branch condition held this cycle.
  output logic O_STATUS_WR // Status flag write enable, never raised.
);

  logic [1:0] rst_sync;
  logic rst_n;
  phase_t phase;
  phase_t next_phase;
  cycle_t cycle;
  decoded_t ir;
  logic [PCW-1:0] ir_pc;
  logic [DADDR_W-1:0] res_addr;
  logic res_indexed;
  logic br_is;
  logic br_taken;
  logic [PC_W-1:0] br_target;
  logic taken_hold;
  logic [7:0] clear_mask;
  logic is_clear;
  decoded_t fetch_dec;

  // One decode of the fetched word feeds both the instruction register and the claim flag.
  assign fetch_dec = decode(I_INSTR_VALID, I_INSTR);

  // Reset is released through two flip-flops.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  always_comb begin
    unique case (phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      PH_Q4: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  assign O_PHASE = phase;

  // The word is decoded at the end of Q1; the idle cycle of a taken branch decodes nothing.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ir <= '0;
      ir_pc <= '0;
    end else if (phase == PH_Q1) begin
      if (cycle == CYC_EXEC) begin
        ir <= fetch_dec;
        ir_pc <= I_INSTR_PC;
      end else begin
        ir <= '0;
        ir_pc <= ir_pc;
      end
    end
  end

  assign is_clear = (ir.op == OP_BIT_CLEAR);

  data_addr_resolver u_addr (
    .bank_sel(ir.bank_sel),
    .faddr(ir.faddr),
    .bank(I_BSR),
    .ext_en(I_EXT_EN),
    .index_base(I_INDEX_BASE),
    .addr(res_addr),
    .indexed(res_indexed)
  );

  branch_eval u_branch (
    .op(ir.op),
    .offset(ir.offset),
    .flags(I_FLAGS),
    .instr_pc(PC_W'(ir_pc)),
    .is_branch(br_is),
    .taken(br_taken),
    .target(br_target)
  );

  // Mask with only the selected bit low.
  always_comb begin
    clear_mask = 8'hff;
    clear_mask[ir.bit_idx] = 1'b0;
  end

  // Read in Q3, write back in Q4, all within one instruction cycle.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_DATA <= '0;
    end else begin
      unique case (phase)
        PH_Q1: begin
          O_DATA.rd <= 1'b0;
          O_DATA.wr <= 1'b0;
        end
        PH_Q2: begin
          O_DATA.addr <= res_addr;
          O_DATA.rd <= is_clear;
        end
        PH_Q3: begin
          O_DATA.rd <= 1'b0;
          O_DATA.wr <= is_clear;
          O_DATA.wdata <= I_DATA_RDATA & clear_mask;
        end
        PH_Q4: begin
          O_DATA.wr <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_INDEXED <= 1'b0;
    end else if (phase == PH_Q2) begin
      O_INDEXED <= is_clear && res_indexed;
    end else if (phase == PH_Q4) begin
      O_INDEXED <= 1'b0;
    end
  end

  // The condition is judged at the end of Q3 and the counter is written during Q4.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PC_WR <= 1'b0;
      O_PC_VALUE <= '0;
      taken_hold <= 1'b0;
    end else if (phase == PH_Q3) begin
      O_PC_WR <= br_is && br_taken;
      O_PC_VALUE <= PCW'(br_target);
      taken_hold <= br_is && br_taken;
    end else begin
      O_PC_WR <= 1'b0;
      if (phase == PH_Q4) begin
        taken_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_BRANCH_TAKEN <= 1'b0;
    end else if (phase == PH_Q3) begin
      O_BRANCH_TAKEN <= br_is && br_taken;
    end else if (phase == PH_Q4) begin
      O_BRANCH_TAKEN <= 1'b0;
    end
  end

  // A taken branch spends the whole following instruction cycle idle.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cycle <= CYC_EXEC;
      O_FLUSH <= 1'b0;
    end else if (phase == PH_Q4) begin
      unique case (cycle)
        CYC_EXEC: begin
          cycle <= taken_hold ? CYC_FLUSH : CYC_EXEC;
          O_FLUSH <= taken_hold;
        end
        CYC_FLUSH: begin
          cycle <= CYC_EXEC;
          O_FLUSH <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_CLAIMED <= 1'b0;
    end else if (phase == PH_Q1) begin
      O_CLAIMED <= (cycle == CYC_EXEC) && (fetch_dec.op != OP_NONE);
    end
  end

  // None of these operations touches a status flag.
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_STATUS_WR <= 1'b0;
    end else begin
      O_STATUS_WR <= 1'b0;
    end
  end

endmodule

// [verilog/bcfb_pkg.sv]
// Shared constants, types and decoding for the bit-clear and flag-branch execute unit.
package bcfb_pkg;

  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int FADDR_W = 8;

  // Opcode fields.
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [7:0] OPC_BR_CARRY = 8'he2;
  localparam logic [7:0] OPC_BR_NO_CARRY = 8'he3;
  localparam logic [7:0] OPC_BR_NEG = 8'he6;
  localparam logic [7:0] OPC_BR_NOT_NEG = 8'he7;
  localparam int NIB_MSB = 15;
  localparam int NIB_LSB = 12;
  localparam int BYTE_MSB = 15;
  localparam int BYTE_LSB = 8;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int BANK_SEL_POS = 8;
  localparam int LOW_MSB = 7;

  // Access bank layout and indexed literal offset limit.
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // The counter has already stepped past the branch word when the target is formed.
  localparam logic [PC_W-1:0] PC_STEP = 21'h2;

  typedef enum logic [2:0] {OP_NONE, OP_BIT_CLEAR, OP_BR_CARRY, OP_BR_NO_CARRY, OP_BR_NEG, OP_BR_NOT_NEG} op_t;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
  typedef enum logic {CYC_EXEC, CYC_FLUSH} cycle_t;

  typedef struct packed {
    op_t op;
    logic [2:0] bit_idx;
    logic bank_sel;
    logic [7:0] faddr;
    logic [7:0] offset;
  } decoded_t;

  typedef struct packed {
    logic carry;
    logic negative;
  } flags_t;

  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } data_req_t;

  function automatic decoded_t decode(input logic valid, input logic [15:0] instr);
    decoded_t d;
    d.op = OP_NONE;
    d.bit_idx = instr[BIT_MSB:BIT_LSB];
    d.bank_sel = instr[BANK_SEL_POS];
    d.faddr = instr[LOW_MSB:0];
    d.offset = instr[LOW_MSB:0];
    if (valid) begin
      if (instr[NIB_MSB:NIB_LSB] == OPC_BIT_CLEAR) begin
        d.op = OP_BIT_CLEAR;
      end else begin
        unique case (instr[BYTE_MSB:BYTE_LSB])
          OPC_BR_CARRY: d.op = OP_BR_CARRY;
          OPC_BR_NO_CARRY: d.op = OP_BR_NO_CARRY;
          OPC_BR_NEG: d.op = OP_BR_NEG;
          OPC_BR_NOT_NEG: d.op = OP_BR_NOT_NEG;
          default: d.op = OP_NONE;
        endcase
      end
    end
    return d;
  endfunction

endpackage

// [verilog/branch_eval.sv]
// Evaluates the condition and target of a conditional relative branch.
`timescale 1ns/1ps
module branch_eval
  import bcfb_pkg::*;
(
  input wire op_t op, // Decoded operation.
  input wire logic [7:0] offset, // Signed word offset.
  input wire flags_t flags, // Status flags.
  input wire logic [PC_W-1:0] instr_pc, // Address of the branch word.
  output logic is_branch, // Operation is one of the branches.
  output logic taken, // Branch condition holds.
  output logic [PC_W-1:0] target // Branch destination.
);

  logic [PC_W-1:0] disp;

  // Sign extend and double the offset so targets stay on even addresses.
  assign disp = {{(PC_W-9){offset[7]}}, offset, 1'b0};
  assign target = instr_pc + PC_STEP + disp;

  always_comb begin
    is_branch = 1'b1;
    taken = 1'b0;
    unique case (op)
      OP_BR_CARRY: taken = flags.carry;
      OP_BR_NO_CARRY: taken = !flags.carry;
      OP_BR_NEG: taken = flags.negative;
      OP_BR_NOT_NEG: taken = !flags.negative;
      OP_NONE, OP_BIT_CLEAR: is_branch = 1'b0;
      default: is_branch = 1'b0;
    endcase
  end

endmodule

// [verilog/data_addr_resolver.sv]
// Resolves the full data address of a bit-clear operand.
`timescale 1ns/1ps
module data_addr_resolver
  import bcfb_pkg::*;
(
  input wire logic bank_sel, // Bank-select bit of the instruction.
  input wire logic [FADDR_W-1:0] faddr, // 8-bit register field.
  input wire logic [BANK_W-1:0] bank, // Bank select register.
  input wire logic ext_en, // Extended instruction set enabled.
  input wire logic [DADDR_W-1:0] index_base, // Base pointer for indexed literal offset.
  output logic [DADDR_W-1:0] addr, // Resolved data address.
  output logic indexed // Indexed literal offset mode in use.
);

  always_comb begin
    indexed = 1'b0;
    if (bank_sel) begin
      addr = {bank, faddr};
    end else if (ext_en && (faddr <= INDEXED_MAX)) begin
      addr = index_base + {{(DADDR_W-FADDR_W){1'b0}}, faddr};
      indexed = 1'b1;
    end else if (faddr <= INDEXED_MAX) begin
      addr = {ACCESS_LOW_BANK, faddr};
    end else begin
      addr = {ACCESS_HIGH_BANK, faddr};
    end
  end

endmodule
